// file: rtl/atarx_exec.sv
`timescale 1ns/100ps
// Function
// - Idle immediate sets busy, enters idle, then clears busy with the interrupt.
// - Initialize sets sectors per track and heads from count and drive/head.
// - Buffer read returns current buffer contents with the read handshake.
// - Multiple read interrupts once per block, not once per sector.
// - Data request qualifies the transfer of each sector, not only at block start.
// - Count is in sectors; whole blocks then one partial block of remainder.
// - Multiple read aborts when block count unset or multiple reads off.
// - Media error posted at block start; request and transfer still happen.
// - Interrupt is raised when data request rises at each block start.
// - Reads move 1 to 256 sectors, zero means 256, from sector number.
// - After success the address registers hold the last sector read.
// - On error stop at failing sector, keep its address and its data.
// - After an error continue only if it was a corrected data error.
// - Only a block count of exactly one sector is supported.
// - Long read returns 516 bytes and skips the stored correction check.
// - Long read handles a single sector only.
// - Long read sends 512 bytes as words then 4 filler bytes.
// - Per sector: busy, load buffer, data request, clear busy, interrupt.
// - LBA bits 27-24 drive/head, 23-16 cyl high, 15-8 cyl low, 7-0 sector.
module atarx_exec
	import atarx_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic busy,
	output logic data_request,
	output logic host_intr,
	output logic idle_mode,
	output logic media_req,
	output logic [27:0] media_lba,
	input wire logic media_wvalid,
	input wire logic [15:0] media_wdata,
	input wire logic media_done,
	input wire logic [1:0] media_status
);
	typedef struct packed {
		atarx_state_e st;
		logic ack;
		logic [31:0] dat;
		logic [7:0] feat;
		logic [7:0] scnt;
		logic [7:0] snum;
		logic [7:0] cyll;
		logic [7:0] cylh;
		logic [7:0] drvh;
		logic [7:0] spt;
		logic [7:0] heads;
		logic [7:0] blk;
		logic bsy;
		logic drq;
		logic intrq;
		logic err;
		logic corr;
		logic abrt;
		logic unc;
		logic idle;
		logic multi;
		logic long_rd;
		logic nomedia;
		logic stop;
		logic [8:0] remain;
		logic [7:0] inblk;
		logic [7:0] wptr;
		logic [7:0] mwidx;
		logic [2:0] fcnt;
		logic mreq;
		logic [27:0] lba;
	} atarx_exec_s;
	atarx_exec_s s;
	atarx_exec_s next_s;

	logic req;
	logic take;
	logic [3:0] idx;
	logic cmd_take;
	logic data_take;
	logic [15:0] buf_word;
	logic [7:0] status;
	logic [7:0] errreg;
	logic blk_start;

	assign req = wb_cyc_i & wb_stb_i;
	assign take = req & s.ack;
	assign idx = wb_adr_i[5:2];
	assign cmd_take = take & wb_we_i & wb_sel_i[0] & (idx == IDX_CMD_STAT)
		& ~s.bsy & ~s.drq;
	assign data_take = take & ~wb_we_i & (idx == IDX_DATA) & s.drq;
	assign blk_start = ~s.multi | (s.inblk == 8'h00);

	// Status and error views built from live flags.
	always_comb begin
		status = 8'h00;
		status[ST_BSY] = s.bsy;
		status[ST_DRDY] = ~s.bsy;
		status[ST_DRQ] = s.drq;
		status[ST_CORR] = s.corr;
		status[ST_ERR] = s.err;
		errreg = 8'h00;
		errreg[ER_UNC] = s.unc;
		errreg[ER_ABRT] = s.abrt;
	end

	atarx_sbuf #(
		.W(16),
		.AW(8)
	) u_sbuf (
		.clk(clk),
		.wr_en(s.st == S_LOAD && media_wvalid),
		.wr_idx(s.mwidx),
		.wr_data(media_wdata),
		.rd_idx(s.wptr),
		.rd_data(buf_word)
	);

	// All control, bus and address state advances here.
	always_comb begin
		logic irq_set;
		logic go_load;
		logic go_xfer;
		logic finish;
		logic [27:0] lba_inc;
		irq_set = 1'b0;
		go_load = 1'b0;
		go_xfer = 1'b0;
		finish = 1'b0;
		lba_inc = {s.drvh[3:0], s.cylh, s.cyll, s.snum} + 28'h000_0001;
		next_s = s;
		next_s.ack = req & ~s.ack;

		// Read data is latched with the acknowledge and held until the next request.
		if (req && !s.ack) begin
			next_s.dat = 32'h0000_0000;
			unique case (idx)
				IDX_DATA: begin
					if (s.st == S_FILL) begin
						next_s.dat = {24'h00_0000, FILL_BYTE};
					end else if (s.drq) begin
						next_s.dat = {16'h0000, buf_word};
					end
				end
				IDX_FEAT_ERR: next_s.dat = {24'h00_0000, errreg};
				IDX_SCNT: next_s.dat = {24'h00_0000, s.scnt};
				IDX_SNUM: next_s.dat = {24'h00_0000, s.snum};
				IDX_CYLL: next_s.dat = {24'h00_0000, s.cyll};
				IDX_CYLH: next_s.dat = {24'h00_0000, s.cylh};
				IDX_DRVH: next_s.dat = {24'h00_0000, s.drvh};
				IDX_CMD_STAT: next_s.dat = {24'h00_0000, status};
				IDX_MULTI: next_s.dat = {24'h00_0000, s.blk};
				IDX_GEOM: next_s.dat = {16'h0000, s.heads, s.spt};
				default: next_s.dat = 32'h0000_0000;
			endcase
		end

		// Task file writes are refused while busy or mid-transfer.
		if (take && wb_we_i && wb_sel_i[0] && !s.bsy && !s.drq) begin
			unique case (idx)
				IDX_FEAT_ERR: next_s.feat = wb_dat_i[7:0];
				IDX_SCNT: next_s.scnt = wb_dat_i[7:0];
				IDX_SNUM: next_s.snum = wb_dat_i[7:0];
				IDX_CYLL: next_s.cyll = wb_dat_i[7:0];
				IDX_CYLH: next_s.cylh = wb_dat_i[7:0];
				IDX_DRVH: next_s.drvh = wb_dat_i[7:0];
				// Any count other than one leaves multiple reads disabled.
				IDX_MULTI: begin
					next_s.blk = (wb_dat_i[7:0] == BLK_SUPPORTED) ?
						BLK_SUPPORTED : 8'h00;
				end
				default: ;
			endcase
		end

		// Command decode from the idle state.
		if (cmd_take) begin
			next_s.err = 1'b0;
			next_s.abrt = 1'b0;
			next_s.unc = 1'b0;
			next_s.corr = 1'b0;
			next_s.stop = 1'b0;
			next_s.multi = 1'b0;
			next_s.long_rd = 1'b0;
			next_s.nomedia = 1'b0;
			next_s.inblk = 8'h00;
			next_s.remain = (wb_dat_i[7:0] == CMD_RDBUF) ? 9'h001 :
				((s.scnt == 8'h00) ? FULL_COUNT : {1'b0, s.scnt});
			unique case (wb_dat_i[7:0])
				CMD_IDLE_A, CMD_IDLE_B: begin
					next_s.bsy = 1'b1;
					next_s.idle = 1'b1;
					next_s.st = S_ACK;
				end
				CMD_INIT: begin
					next_s.spt = s.scnt;
					next_s.heads = {4'h0, s.drvh[3:0]} + 8'h01;
					next_s.bsy = 1'b1;
					next_s.st = S_ACK;
				end
				CMD_RDBUF: begin
					next_s.nomedia = 1'b1;
					go_xfer = 1'b1;
				end
				CMD_RDMUL: begin
					if (s.blk == 8'h00) begin
						next_s.err = 1'b1;
						next_s.abrt = 1'b1;
						irq_set = 1'b1;
					end else begin
						next_s.multi = 1'b1;
						go_load = 1'b1;
					end
				end
				CMD_RDLONG_A, CMD_RDLONG_B: begin
					next_s.long_rd = 1'b1;
					next_s.remain = 9'h001;
					go_load = 1'b1;
				end
				default: begin
					next_s.err = 1'b1;
					next_s.abrt = 1'b1;
					irq_set = 1'b1;
				end
			endcase
		end

		unique case (s.st)
			S_IDLE: ;
			// One busy cycle, then busy falls with the interrupt.
			S_ACK: begin
				next_s.bsy = 1'b0;
				irq_set = 1'b1;
				next_s.st = S_IDLE;
			end
			S_LOAD: begin
				if (media_wvalid) begin
					next_s.mwidx = s.mwidx + 8'h01;
				end
				if (media_done) begin
					next_s.mreq = 1'b0;
					// Long reads skip the correction check entirely.
					if (!s.long_rd && media_status == MED_CORR) begin
						next_s.corr = 1'b1;
					end
					if (!s.long_rd && media_status == MED_UNC) begin
						next_s.err = 1'b1;
						next_s.unc = 1'b1;
						next_s.stop = 1'b1;
					end
					go_xfer = 1'b1;
				end
			end
			S_XFER: begin
				if (data_take) begin
					next_s.wptr = s.wptr + 8'h01;
					if (s.wptr == SECT_LAST) begin
						if (s.long_rd) begin
							next_s.st = S_FILL;
							next_s.fcnt = 3'h0;
						end else begin
							finish = 1'b1;
						end
					end
				end
			end
			S_FILL: begin
				if (data_take) begin
					next_s.fcnt = s.fcnt + 3'h1;
					if (s.fcnt == LONG_LAST) begin
						finish = 1'b1;
					end
				end
			end
			default: next_s.st = S_IDLE;
		endcase

		// A drained sector either ends the command or starts the next.
		if (finish) begin
			next_s.drq = 1'b0;
			next_s.remain = s.remain - 9'h001;
			next_s.inblk = s.inblk - 8'h01;
			if (s.remain == 9'h001 || s.nomedia ||
				(s.stop && (!s.multi || s.inblk == 8'h01))) begin
				next_s.st = S_IDLE;
			end else begin
				// Step the address only when another sector follows.
				if (s.drvh[DH_LBA]) begin
					next_s.snum = lba_inc[7:0];
					next_s.cyll = lba_inc[15:8];
					next_s.cylh = lba_inc[23:16];
					next_s.drvh[3:0] = lba_inc[27:24];
				end else if (s.snum >= s.spt) begin
					next_s.snum = 8'h01;
					if ({4'h0, s.drvh[3:0]} + 8'h01 >= s.heads) begin
						next_s.drvh[3:0] = 4'h0;
						{next_s.cylh, next_s.cyll} = {s.cylh, s.cyll} + 16'h0001;
					end else begin
						next_s.drvh[3:0] = s.drvh[3:0] + 4'h1;
					end
				end else begin
					next_s.snum = s.snum + 8'h01;
				end
				go_load = 1'b1;
			end
		end

		// Loading a sector holds busy with data request low.
		if (go_load) begin
			next_s.bsy = 1'b1;
			next_s.drq = 1'b0;
			next_s.mreq = 1'b1;
			next_s.mwidx = 8'h00;
			next_s.st = S_LOAD;
			next_s.lba = {next_s.drvh[3:0], next_s.cylh, next_s.cyll,
				next_s.snum};
		end

		// Present the buffer: data request up, busy down, interrupt per block.
		if (go_xfer) begin
			next_s.drq = 1'b1;
			next_s.bsy = 1'b0;
			next_s.wptr = 8'h00;
			next_s.st = S_XFER;
			if (blk_start) begin
				next_s.inblk = (s.remain < {1'b0, s.blk}) || !s.multi ?
					s.remain[7:0] : s.blk;
				irq_set = 1'b1;
			end
		end

		// Reading status clears the interrupt, but a new event wins.
		if (take && !wb_we_i && idx == IDX_CMD_STAT) begin
			next_s.intrq = 1'b0;
		end
		if (irq_set) begin
			next_s.intrq = 1'b1;
		end
		if (cmd_take && !(wb_dat_i[7:0] == CMD_IDLE_A ||
			wb_dat_i[7:0] == CMD_IDLE_B)) begin
			next_s.idle = 1'b0;
		end
	end

	// Multiple reads start disabled; geometry starts at its default.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
			s.st <= S_IDLE;
			s.spt <= SPT_RESET;
			s.heads <= HEADS_RESET;
			s.blk <= 8'h00;
			s.snum <= 8'h01;
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign busy = s.bsy;
	assign data_request = s.drq;
	assign host_intr = s.intrq;
	assign idle_mode = s.idle;
	assign media_req = s.mreq;
	assign media_lba = s.lba;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence seq_busy_then_irq;
		s.bsy ##1 (!s.bsy && s.intrq && s.idle);
	endsequence

	a_ack_single: assert property (s.ack |=> !s.ack)
		else $error("ack stood two cycles");
	a_idle_sequence: assert property (
		cmd_take && wb_dat_i[7:0] == CMD_IDLE_A |=> seq_busy_then_irq)
		else $error("idle immediate sequence wrong");
	a_init_geometry: assert property (
		cmd_take && wb_dat_i[7:0] == CMD_INIT |=> s.spt == $past(s.scnt))
		else $error("sectors per track not taken");
	a_multi_abort: assert property (
		cmd_take && wb_dat_i[7:0] == CMD_RDMUL && s.blk == 8'h00
		|=> s.err && s.abrt && !s.bsy && s.st == S_IDLE)
		else $error("multiple read not aborted");
	a_load_busy: assert property (s.mreq |-> s.bsy && !s.drq)
		else $error("load without busy");
	a_block_irq: assert property (
		s.st == S_LOAD && media_done && blk_start
		|=> s.drq && s.intrq && !s.bsy)
		else $error("block start without interrupt");
	a_long_single: assert property (s.long_rd && s.st != S_IDLE
		|-> s.remain == 9'h001)
		else $error("long read over one sector");
	a_filler_byte: assert property (
		s.st == S_FILL && s.ack |-> s.dat[31:8] == 24'h00_0000)
		else $error("filler not in byte lane");
	a_blk_one: assert property (s.blk == 8'h00 || s.blk == 8'h01)
		else $error("unsupported block count held");
endmodule : atarx_exec

// file: rtl/atarx_pkg.sv
package atarx_pkg;
	// Wishbone word index (address bits 5:2) of each register.
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_FEAT_ERR = 4'h1;
	localparam logic [3:0] IDX_SCNT = 4'h2;
	localparam logic [3:0] IDX_SNUM = 4'h3;
	localparam logic [3:0] IDX_CYLL = 4'h4;
	localparam logic [3:0] IDX_CYLH = 4'h5;
	localparam logic [3:0] IDX_DRVH = 4'h6;
	localparam logic [3:0] IDX_CMD_STAT = 4'h7;
	localparam logic [3:0] IDX_MULTI = 4'h8;
	localparam logic [3:0] IDX_GEOM = 4'h9;
	// Command codes handled by this block.
	localparam logic [7:0] CMD_IDLE_A = 8'hE1;
	localparam logic [7:0] CMD_IDLE_B = 8'h95;
	localparam logic [7:0] CMD_INIT = 8'h91;
	localparam logic [7:0] CMD_RDBUF = 8'hE4;
	localparam logic [7:0] CMD_RDMUL = 8'hC4;
	localparam logic [7:0] CMD_RDLONG_A = 8'h22;
	localparam logic [7:0] CMD_RDLONG_B = 8'h23;
	// Status, error and drive/head register bit positions.
	localparam int ST_BSY = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DRQ = 3;
	localparam int ST_CORR = 2;
	localparam int ST_ERR = 0;
	localparam int ER_UNC = 6;
	localparam int ER_ABRT = 2;
	localparam int DH_LBA = 6;
	// Sector geometry and transfer constants.
	localparam logic [7:0] SECT_LAST = 8'hFF;
	localparam logic [2:0] LONG_LAST = 3'h3;
	localparam logic [7:0] FILL_BYTE = 8'hA5;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	localparam logic [7:0] BLK_SUPPORTED = 8'h01;
	localparam logic [7:0] SPT_RESET = 8'h20;
	localparam logic [7:0] HEADS_RESET = 8'h10;
	// Media completion status codes.
	localparam logic [1:0] MED_OK = 2'h0;
	localparam logic [1:0] MED_CORR = 2'h1;
	localparam logic [1:0] MED_UNC = 2'h2;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ACK = 3'b001,
		S_LOAD = 3'b010,
		S_XFER = 3'b011,
		S_FILL = 3'b100
	} atarx_state_e;
endpackage : atarx_pkg

// file: rtl/atarx_sbuf.sv
`timescale 1ns/100ps
// Sector buffer held in flip-flops, written by the media side and read by
// index on the host side; the read is combinational so the bus can latch it.
module atarx_sbuf #(
	parameter int W = 16,
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [W-1:0] wr_data,
	input wire logic [AW-1:0] rd_idx,
	output logic [W-1:0] rd_data
);
	typedef struct packed {
		logic [(1<<AW)-1:0][W-1:0] mem;
	} atarx_sbuf_s;
	atarx_sbuf_s s;
	atarx_sbuf_s next_s;

	// Data storage needs no reset; stale contents are what a buffer read shows.
	always_comb begin
		next_s = s;
		if (wr_en) begin
			next_s.mem[wr_idx] = wr_data;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	assign rd_data = s.mem[rd_idx];
endmodule : atarx_sbuf

// file: dv/atarx_media.sv
`timescale 1ns/100ps
// Behavioural flash side: answers each sector load with 256 words and a
// completion pulse. It only fails on the address that the bench names.
module atarx_media
	import atarx_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic media_req,
	input wire logic [27:0] media_lba,
	input wire logic [27:0] bad_lba,
	input wire logic [1:0] bad_code,
	input wire logic slow,
	output logic media_wvalid,
	output logic [15:0] media_wdata,
	output logic media_done,
	output logic [1:0] media_status
);
	logic [8:0] cnt;
	logic run;
	logic hold;
	logic tgl;

	// Word k of a sector carries the low address byte and k, so a wrong
	// sector or a slipped index shows up; idle lines toggle as garbage.
	always @(posedge clk) begin
		if (!resetn) begin
			{run, hold, tgl, cnt} <= '0;
			{media_wvalid, media_done, media_status} <= '0;
			media_wdata <= 16'h5a5a;
		end else begin
			media_wvalid <= 1'b0;
			media_done <= 1'b0;
			media_wdata <= ~media_wdata;
			media_status <= ~media_status;
			tgl <= ~tgl;
			if (!media_req)
				hold <= 1'b0;
			if (media_req && !run && !hold) begin
				run <= 1'b1;
				cnt <= '0;
			end else if (run && cnt[8]) begin
				media_done <= 1'b1;
				media_status <= (media_lba == bad_lba) ? bad_code : MED_OK;
				run <= 1'b0;
				hold <= 1'b1;
			end else if (run && !(slow && tgl)) begin
				media_wvalid <= 1'b1;
				media_wdata <= {media_lba[7:0], cnt[7:0]};
				cnt <= cnt + 9'h001;
			end
		end
	end
endmodule : atarx_media

// file: dv/tb_ata_read_command_executor.sv
`timescale 1ns/100ps
module tb_ata_read_command_executor
	import atarx_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [5:0] wb_adr = '0;
	logic [31:0] wb_dat = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic busy, data_request, host_intr, idle_mode, media_req;
	logic [27:0] media_lba;
	logic media_wvalid, media_done;
	logic [15:0] media_wdata;
	logic [1:0] media_status;
	logic [27:0] bad_lba = '1;
	logic [1:0] bad_code = MED_OK;
	logic slow = 1'b0;
	int fails = 0;
	int total_checks = 0;
	logic [31:0] q;

	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	atarx_exec i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack), .busy(busy), .data_request(data_request),
		.host_intr(host_intr), .idle_mode(idle_mode), .media_req(media_req),
		.media_lba(media_lba), .media_wvalid(media_wvalid),
		.media_wdata(media_wdata), .media_done(media_done),
		.media_status(media_status));

	atarx_media i_media (.clk(clk), .resetn(resetn), .media_req(media_req),
		.media_lba(media_lba), .bad_lba(bad_lba), .bad_code(bad_code),
		.slow(slow), .media_wvalid(media_wvalid), .media_wdata(media_wdata),
		.media_done(media_done), .media_status(media_status));

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One classic cycle; the request stands until ack is sampled high.
	task wb_io(input logic w, input logic [3:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= {idx, 2'b00};
		wb_dat <= {24'h00_0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		chk("ack", 32'h0000_0001, {31'h0, wb_ack});
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb_io

	// Bounded wait for the interrupt line.
	task wait_irq;
		int n;
		n = 0;
		while (host_intr !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		chk("irq", 32'h0000_0001, {31'h0, host_intr});
	endtask : wait_irq

	// The host drains one whole sector after each interrupt.
	task rd_sect(input logic [7:0] lo, input logic [7:0] st);
		wait_irq;
		wb_io(1'b0, IDX_CMD_STAT, 8'h00);
		chk("status", {24'h00_0000, st}, q);
		for (int i = 0; i < 256; i++) begin
			wb_io(1'b0, IDX_DATA, 8'h00);
			chk("word", {16'h0000, lo, i[7:0]}, {16'h0000, q[15:0]});
		end
	endtask : rd_sect

	task issue(input logic [7:0] sc, input logic [7:0] sn, input logic [7:0] c);
		wb_io(1'b1, IDX_SCNT, sc);
		wb_io(1'b1, IDX_SNUM, sn);
		wb_io(1'b1, IDX_CMD_STAT, c);
	endtask : issue

	// Ends a run that hangs well past the expected span.
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		end_sim;
	end

	// Main sequence of command scenarios.
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		wb_io(1'b0, IDX_GEOM, 8'h00);
		chk("geom_rst", {16'h0000, HEADS_RESET, SPT_RESET}, q);
		for (int k = 0; k < 2; k++) begin
			wb_io(1'b1, IDX_CMD_STAT, k ? CMD_IDLE_B : CMD_IDLE_A);
			wait_irq;
			chk("idle", 32'h0000_0001, {31'h0, idle_mode});
			wb_io(1'b0, IDX_CMD_STAT, 8'h00);
			chk("idle_st", 32'h0000_0040, q);
		end
		wb_io(1'b1, IDX_DRVH, 8'he3);
		issue(8'h11, 8'h01, CMD_INIT);
		wait_irq;
		wb_io(1'b0, IDX_GEOM, 8'h00);
		chk("geom", 32'h0000_0411, q);
		chk("idle_off", 32'h0, {31'h0, idle_mode});
		wb_io(1'b1, IDX_DRVH, 8'he0);
		wb_io(1'b1, IDX_CYLL, 8'h00);
		wb_io(1'b1, IDX_CYLH, 8'h00);
		issue(8'h02, 8'h05, CMD_RDMUL);
		wait_irq;
		wb_io(1'b0, IDX_FEAT_ERR, 8'h00);
		chk("abort", 32'h0000_0004, q);
		wb_io(1'b0, IDX_CMD_STAT, 8'h00);
		chk("abort_st", 32'h0000_0041, q);
		// Set the block count first, as a host must; slow media stalls loads.
		wb_io(1'b1, IDX_MULTI, BLK_SUPPORTED);
		slow <= 1'b1;
		issue(8'h02, 8'h05, CMD_RDMUL);
		rd_sect(8'h05, 8'h48);
		rd_sect(8'h06, 8'h48);
		repeat (4) @(posedge clk);
		chk("no_irq", 32'h0, {31'h0, host_intr});
		wb_io(1'b0, IDX_SNUM, 8'h00);
		chk("last_sn", 32'h0000_0006, q);
		slow <= 1'b0;
		bad_lba <= 28'h000_0011;
		bad_code <= MED_UNC;
		issue(8'h03, 8'h10, CMD_RDMUL);
		rd_sect(8'h10, 8'h48);
		rd_sect(8'h11, 8'h49);
		repeat (8) @(posedge clk);
		chk("stop", 32'h0, {31'h0, media_req | busy | data_request});
		wb_io(1'b0, IDX_FEAT_ERR, 8'h00);
		chk("unc", 32'h0000_0040, q);
		wb_io(1'b0, IDX_SNUM, 8'h00);
		chk("fail_sn", 32'h0000_0011, q);
		bad_lba <= 28'h000_0021;
		bad_code <= MED_CORR;
		issue(8'h03, 8'h20, CMD_RDMUL);
		rd_sect(8'h20, 8'h48);
		rd_sect(8'h21, 8'h4c);
		// The corrected flag stays posted until the next command is taken.
		rd_sect(8'h22, 8'h4c);
		wb_io(1'b0, IDX_SNUM, 8'h00);
		chk("corr_sn", 32'h0000_0022, q);
		// Both long-read codes: a bad address proves the check is skipped.
		bad_lba <= 28'h000_0030;
		bad_code <= MED_UNC;
		for (int k = 0; k < 2; k++) begin
			issue(8'h01, 8'h30, k ? CMD_RDLONG_B : CMD_RDLONG_A);
			rd_sect(8'h30, 8'h48);
			for (int i = 0; i < 4; i++) begin
				wb_io(1'b0, IDX_DATA, 8'h00);
				chk("fill", {24'h00_0000, FILL_BYTE}, {24'h00_0000, q[7:0]});
			end
		end
		issue(8'h01, 8'h00, CMD_RDBUF);
		rd_sect(8'h30, 8'h48);
		chk("no_media", 32'h0, {31'h0, media_req});
		end_sim;
	end
endmodule : tb_ata_read_command_executor
